// File: verilog/pecbc_regs.sv
// error counter and self-test control register bank on an Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none
module pecbc_regs
    import pecbc_pkg::*;
(
    input  wire logic              clk,                // 100 MHz clock
    input  wire logic              rst,                // async reset, high
    input  wire logic [ADDR_W-1:0] avs_address,        // byte address
    input  wire logic              avs_read,           // read request
    input  wire logic              avs_write,          // write request
    input  wire logic [31:0]       avs_writedata,      // write data
    input  wire logic [3:0]        avs_byteenable,     // write lanes
    output logic [31:0]            avs_readdata,       // read data
    output logic                   avs_waitrequest,    // low for one answer cycle
    input  wire logic              false_carrier_evt,  // one false carrier
    input  wire logic              rx_dv,              // receive data valid
    input  wire logic              rx_symbol_err,      // invalid data symbol seen
    input  wire logic              mii_loopback,       // MII loopback active
    input  wire logic              prbs_error_evt,     // checker bit error
    input  wire logic              prbs_lock,          // checker locked
    input  wire logic              prbs_sync_loss_evt, // checker lost sync
    input  wire logic              gen_active,         // generator sending
    input  wire logic              power_normal,       // normal power mode
    output logic                   prbs_count_mode,    // continuous error count
    output logic                   prbs_packet_mode,   // PRBS packets selected
    output logic                   gen_enable,         // start generator
    output logic                   gen_continuous,     // continuous PRBS packets
    output logic                   prbs_checker_en,    // checker enabled
    output logic                   tx_in_loopback,     // transmit during loopback
    output logic [LB_W-1:0]        loopback_sel,       // one-hot or zero loopback point
    output logic                   prbs_count_wrap,    // error counter wrapped
    output logic                   fc_half_full_evt,   // false carrier half full
    output logic                   re_half_full_evt    // receive error half full
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic            waitreq;
        logic [31:0]     rdata;
        logic            count_mode;
        logic            packet_mode;
        logic            gen_en;
        logic            gen_cont;
        logic            chk_en;
        logic            tx_lb;
        logic [LB_W-1:0] lb_sel;
        logic            sync_loss;
        logic            fc_flag;
        logic            re_flag;
        logic            fc_en;
        logic            re_en;
    } pecbc_state_t;

    pecbc_state_t s_q, s_d;

    logic [FC_W-1:0]   fc_count;
    logic [RE_W-1:0]   re_count;
    logic [BIST_W-1:0] bist_count;
    logic              fc_half, re_half, bist_wrap;
    logic              accept, rd_fc, rd_re, rd_st, rd_is, wr_st, wr_is;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [5:0] idx);
        hit = (addr[ADDR_W-1:2] == idx);
    endfunction : hit

    // byte lanes 0 and 1 carry the 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] wd,
                                            input logic [3:0] be);
        merge16 = old_v;
        if (be[0]) begin
            merge16[7:0] = wd[7:0];
        end
        if (be[1]) begin
            merge16[15:8] = wd[15:8];
        end
    endfunction : merge16

    function automatic logic legal_lb(input logic [LB_W-1:0] v);
        legal_lb = (v == '0) || ($countones(v) == 1);
    endfunction : legal_lb

    // ------------------------------------------------------------------
    // register views
    // ------------------------------------------------------------------
    logic [15:0] st_view, is_view;

    always_comb begin
        st_view                 = 16'h0000;
        st_view[ST_COUNT_MODE]  = s_q.count_mode;
        st_view[ST_PACKET_MODE] = s_q.packet_mode;
        st_view[ST_GEN_EN]      = s_q.gen_en;
        st_view[ST_LOCK]        = prbs_lock;
        st_view[ST_SYNC_LOSS]   = s_q.sync_loss;
        st_view[ST_GEN_STATUS]  = gen_active;
        st_view[ST_POWER_MODE]  = power_normal;
        st_view[ST_TX_LOOPBACK] = s_q.tx_lb;
        st_view[ST_LB_LSB +: LB_W] = s_q.lb_sel;
        is_view                 = 16'h0000;
        is_view[IS_FC_FLAG]     = s_q.fc_flag;
        is_view[IS_RE_FLAG]     = s_q.re_flag;
        is_view[IS_FC_EN]       = s_q.fc_en;
        is_view[IS_RE_EN]       = s_q.re_en;
    end

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    // a request is taken once, on the first edge that sees it with waitrequest high
    assign accept = (avs_read || avs_write) && s_q.waitreq;
    assign rd_fc  = accept && avs_read && hit(avs_address, IDX_FALSE_CAR);
    assign rd_re  = accept && avs_read && hit(avs_address, IDX_RX_ERR);
    assign rd_st  = accept && avs_read && hit(avs_address, IDX_SELF_TEST);
    assign rd_is  = accept && avs_read && hit(avs_address, IDX_INT_STATUS);
    assign wr_st  = accept && avs_write && hit(avs_address, IDX_SELF_TEST);
    assign wr_is  = accept && avs_write && hit(avs_address, IDX_INT_STATUS);

    // ------------------------------------------------------------------
    // counters
    // ------------------------------------------------------------------
    pecbc_sat_counter #(.WIDTH(FC_W)) u_fc_cnt (
        .clk      (clk),
        .rst      (rst),
        .inc      (false_carrier_evt),
        .clr      (rd_fc),
        .hold     (1'b0),
        .wrap_en  (1'b0),
        .count    (fc_count),
        .half_evt (fc_half),
        .wrap_evt ()
    );

    pecbc_sat_counter #(.WIDTH(RE_W)) u_re_cnt (
        .clk      (clk),
        .rst      (rst),
        .inc      (rx_dv && rx_symbol_err),
        .clr      (rd_re),
        .hold     (mii_loopback),
        .wrap_en  (1'b0),
        .count    (re_count),
        .half_evt (re_half),
        .wrap_evt ()
    );

    // checker error count, zeroed whenever the checker is off
    pecbc_sat_counter #(.WIDTH(BIST_W)) u_bist_cnt (
        .clk      (clk),
        .rst      (rst),
        .inc      (prbs_error_evt && s_q.chk_en),
        .clr      (!s_q.chk_en),
        .hold     (1'b0),
        .wrap_en  (s_q.count_mode),
        .count    (bist_count),
        .half_evt (),
        .wrap_evt (bist_wrap)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [15:0] st_new;
        logic [15:0] is_new;
        st_new    = merge16(st_view, avs_writedata, avs_byteenable);
        is_new    = merge16(is_view, avs_writedata, avs_byteenable);
        s_d       = s_q;
        s_d.waitreq = !accept;
        if (accept && avs_read) begin
            s_d.rdata = UNMAPPED_DATA;
            if (hit(avs_address, IDX_FALSE_CAR)) begin
                s_d.rdata = {{(32-FC_W){1'b0}}, fc_count};
            end else if (hit(avs_address, IDX_RX_ERR)) begin
                s_d.rdata = {{(32-RE_W){1'b0}}, re_count};
            end else if (hit(avs_address, IDX_SELF_TEST)) begin
                s_d.rdata = {16'h0000, st_view};
            end else if (hit(avs_address, IDX_INT_STATUS)) begin
                s_d.rdata = {16'h0000, is_view};
            end
        end
        if (wr_st) begin
            s_d.count_mode  = st_new[ST_COUNT_MODE];
            s_d.packet_mode = st_new[ST_PACKET_MODE];
            s_d.gen_en      = st_new[ST_GEN_EN];
            s_d.tx_lb       = st_new[ST_TX_LOOPBACK];
            // an illegal loopback code would select two points at once, so it is dropped
            if (legal_lb(st_new[ST_LB_LSB +: LB_W])) begin
                s_d.lb_sel  = st_new[ST_LB_LSB +: LB_W];
            end
        end
        s_d.gen_cont = s_d.packet_mode;
        s_d.chk_en   = s_d.packet_mode;
        // sync loss latches; a new loss in the reading cycle wins over the clear
        s_d.sync_loss = (s_q.sync_loss && !rd_st) ||
                        (prbs_sync_loss_evt && s_q.chk_en);
        if (wr_is) begin
            s_d.fc_en = is_new[IS_FC_EN];
            s_d.re_en = is_new[IS_RE_EN];
        end
        s_d.fc_flag = (s_q.fc_flag && !rd_is) || fc_half;
        s_d.re_flag = (s_q.re_flag && !rd_is) || re_half;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q         <= '0;
            s_q.waitreq <= 1'b1;
            s_q.rdata   <= RDATA_RST;
            s_q.lb_sel  <= LB_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign avs_readdata     = s_q.rdata;
    assign avs_waitrequest  = s_q.waitreq;
    assign prbs_count_mode  = s_q.count_mode;
    assign prbs_packet_mode = s_q.packet_mode;
    assign gen_enable       = s_q.gen_en;
    assign gen_continuous   = s_q.gen_cont;
    assign prbs_checker_en  = s_q.chk_en;
    assign tx_in_loopback   = s_q.tx_lb;
    assign loopback_sel     = s_q.lb_sel;
    assign prbs_count_wrap  = bist_wrap;
    assign fc_half_full_evt = fc_half;
    assign re_half_full_evt = re_half;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_req_taken;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_one_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    a_bus_one_answer: assert property (@(posedge clk) disable iff (rst)
        s_req_taken |=> s_one_answer)
        else $error("request not answered in exactly one cycle");
    a_fc_upper_zero: assert property (@(posedge clk) disable iff (rst)
        rd_fc |=> avs_readdata[31:FC_W] == '0)
        else $error("false carrier upper bits not zero");
    a_fc_read_clears: assert property (@(posedge clk) disable iff (rst)
        (rd_fc && !false_carrier_evt) |=> fc_count == '0)
        else $error("false carrier count not cleared by read");
    a_lock_readback: assert property (@(posedge clk) disable iff (rst)
        rd_st |=> avs_readdata[ST_LOCK] == $past(prbs_lock))
        else $error("lock bit does not follow checker");
    a_sync_loss_held: assert property (@(posedge clk) disable iff (rst)
        (s_q.sync_loss && !rd_st) |=> s_q.sync_loss)
        else $error("sync loss dropped before read");
    a_gen_status_read: assert property (@(posedge clk) disable iff (rst)
        rd_st |=> avs_readdata[ST_GEN_STATUS] == $past(gen_active))
        else $error("generator status misreported");
    a_flag_on_half: assert property (@(posedge clk) disable iff (rst)
        (fc_half || re_half) |=> (s_q.fc_flag || !$past(fc_half)) && (s_q.re_flag || !$past(re_half)))
        else $error("half-full event did not set its flag");
    a_lb_one_hot: assert property (@(posedge clk) disable iff (rst)
        wr_st |=> legal_lb(loopback_sel))
        else $error("loopback selection not one-hot");
    a_gen_enable_write: assert property (@(posedge clk) disable iff (rst)
        (wr_st && avs_byteenable[1]) |=> gen_enable == $past(avs_writedata[ST_GEN_EN]))
        else $error("generator enable did not take write");
    a_checker_follows: assert property (@(posedge clk) disable iff (rst)
        wr_st ##1 1'b1 |-> prbs_checker_en == prbs_packet_mode && gen_continuous == prbs_packet_mode)
        else $error("checker enable does not follow packet mode");
endmodule : pecbc_regs
`default_nettype wire

// File: verilog/pecbc_pkg.sv
// constants for the error counter and self-test register bank
//
// What this block does
// - each false carrier event adds one to an 8-bit counter
// - false carrier counter stops at its maximum and never wraps
// - false carrier count passing half full raises a half-full event
// - reading either counter register returns the count, then zeroes that counter
// - upper byte of false carrier register ignores writes and reads zero
// - receive error counter counts symbol errors only while receive data valid
// - receive error counter holds while MII loopback is active
// - receive error counter stops at its maximum and never wraps
// - receive error count passing half full raises a half-full event
// - count mode bit: continuous wraps with a pulse, single stops at maximum
// - packet bit: set gives continuous PRBS packets and checker; clear gives one constant packet
// - generation enable bit starts or stops the generator, reset to zero
// - lock bit reads one while the checker is locked
// - sync loss bit latches high on loss of sync until read
// - generator status bit reads one while the generator is active
// - self-test register also holds the loopback point selection
// - loopback selection is a five-bit one-hot code, or all zero
// - half-full events set clear-on-read status flags, each with its own enable
package pecbc_pkg;
    // --------------------------------------------------------------
    // register indices, byte address is four times the index
    // --------------------------------------------------------------
    localparam int unsigned ADDR_W          = 8;
    localparam logic [5:0]  IDX_INT_STATUS  = 6'h12;
    localparam logic [5:0]  IDX_FALSE_CAR   = 6'h14;
    localparam logic [5:0]  IDX_RX_ERR      = 6'h15;
    localparam logic [5:0]  IDX_SELF_TEST   = 6'h16;
    // --------------------------------------------------------------
    // widths
    // --------------------------------------------------------------
    localparam int unsigned FC_W            = 8;
    localparam int unsigned RE_W            = 16;
    localparam int unsigned BIST_W          = 16;
    localparam int unsigned LB_W            = 5;
    // --------------------------------------------------------------
    // self-test register fields
    // --------------------------------------------------------------
    localparam int unsigned ST_COUNT_MODE   = 14;
    localparam int unsigned ST_PACKET_MODE  = 13;
    localparam int unsigned ST_GEN_EN       = 12;
    localparam int unsigned ST_LOCK         = 11;
    localparam int unsigned ST_SYNC_LOSS    = 10;
    localparam int unsigned ST_GEN_STATUS   = 9;
    localparam int unsigned ST_POWER_MODE   = 8;
    localparam int unsigned ST_TX_LOOPBACK  = 6;
    localparam int unsigned ST_LB_LSB       = 0;
    // --------------------------------------------------------------
    // interrupt status one register fields
    // --------------------------------------------------------------
    localparam int unsigned IS_FC_FLAG      = 9;
    localparam int unsigned IS_RE_FLAG      = 8;
    localparam int unsigned IS_FC_EN        = 1;
    localparam int unsigned IS_RE_EN        = 0;
    // --------------------------------------------------------------
    // reset values and unmapped read data
    // --------------------------------------------------------------
    localparam logic [31:0]   RDATA_RST     = 32'h0000_0000;
    localparam logic [LB_W-1:0] LB_RST      = 5'h00;
    localparam logic [31:0]   UNMAPPED_DATA = 32'h0000_0000;
endpackage : pecbc_pkg

// File: verilog/pecbc_sat_counter.sv
// saturating or wrapping event counter with clear and half-full event
`timescale 1ns/1ps
`default_nettype none
module pecbc_sat_counter
    import pecbc_pkg::*;
#(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             clk,      // system clock
    input  wire logic             rst,      // async reset, high
    input  wire logic             inc,      // one count per cycle
    input  wire logic             clr,      // zero the counter
    input  wire logic             hold,     // freeze counting
    input  wire logic             wrap_en,  // wrap at maximum instead of stopping
    output logic [WIDTH-1:0]      count,    // current count
    output logic                  half_evt, // pulse on passing half full
    output logic                  wrap_evt  // pulse on wrapping
);
    localparam logic [WIDTH-1:0] MAX_C  = {WIDTH{1'b1}};
    localparam logic [WIDTH-1:0] HALF_C = {1'b0, {(WIDTH-1){1'b1}}};

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic             half;
        logic             wrap;
    } pecbc_cnt_state_t;

    pecbc_cnt_state_t s_q, s_d;

    // an increment in the clearing cycle counts from zero, so no event is lost
    always_comb begin
        logic [WIDTH-1:0] base;
        base      = clr ? '0 : s_q.cnt;
        s_d       = s_q;
        s_d.half  = 1'b0;
        s_d.wrap  = 1'b0;
        s_d.cnt   = base;
        if (inc && !hold) begin
            if (base == MAX_C) begin
                if (wrap_en) begin
                    s_d.cnt  = '0;
                    s_d.wrap = 1'b1;
                end
            end else begin
                s_d.cnt  = base + 1'b1;
                s_d.half = (base == HALF_C);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign count    = s_q.cnt;
    assign half_evt = s_q.half;
    assign wrap_evt = s_q.wrap;

    a_sat_no_wrap: assert property (@(posedge clk) disable iff (rst)
        (inc && !hold && !clr && !wrap_en && s_q.cnt == MAX_C) |=> s_q.cnt == MAX_C)
        else $error("counter left its maximum in single mode");
    a_half_event_once: assert property (@(posedge clk) disable iff (rst)
        s_q.half |-> (s_q.cnt == HALF_C + 1'b1) && !$past(s_q.half))
        else $error("half-full event not at crossing");
    a_clear_to_zero: assert property (@(posedge clk) disable iff (rst)
        (clr && !(inc && !hold)) |=> s_q.cnt == '0)
        else $error("counter not zero after clear");
    a_hold_stable: assert property (@(posedge clk) disable iff (rst)
        (hold && !clr) |=> $stable(s_q.cnt))
        else $error("counter moved while held");
endmodule : pecbc_sat_counter
`default_nettype wire

// File: tb/pecbc_far_model.sv
// far side model driving line events and self-test status into the bank
`timescale 1ns/1ps
`default_nettype none
module pecbc_far_model (
    input  wire logic clk,                // system clock
    input  wire logic gen_enable,         // generator start from the bank
    output var logic  false_carrier_evt,  // false carrier pulse
    output var logic  rx_dv,              // receive data valid
    output var logic  rx_symbol_err,      // symbol error pulse
    output var logic  mii_loopback,       // loopback level
    output var logic  prbs_error_evt,     // checker bit error pulse
    output var logic  prbs_lock,          // checker locked
    output var logic  prbs_sync_loss_evt, // checker lost sync
    output var logic  gen_active,         // generator sending
    output var logic  power_normal        // normal power mode
);
    initial {false_carrier_evt, rx_dv, rx_symbol_err, mii_loopback, prbs_error_evt, prbs_lock,
        prbs_sync_loss_evt, gen_active, power_normal} = '0;
    // the generator reports activity one cycle after it is started
    always @(posedge clk) gen_active <= gen_enable;
    task automatic fc(input int n);
        @(posedge clk);
        false_carrier_evt <= 1'b1;
        repeat (n) @(posedge clk);
        false_carrier_evt <= 1'b0;
    endtask : fc
    task automatic pe(input int n);
        @(posedge clk);
        prbs_error_evt <= 1'b1;
        repeat (n) @(posedge clk);
        prbs_error_evt <= 1'b0;
    endtask : pe
    task automatic re(input int n, input logic dv, input logic lb);
        @(posedge clk);
        {rx_dv, mii_loopback, rx_symbol_err} <= {dv, lb, 1'b1};
        repeat (n) @(posedge clk);
        {rx_dv, mii_loopback, rx_symbol_err} <= 3'b000;
    endtask : re
    task automatic sync_loss();
        @(posedge clk);
        prbs_sync_loss_evt <= 1'b1;
        @(posedge clk);
        prbs_sync_loss_evt <= 1'b0;
    endtask : sync_loss
    task automatic lv(input logic lock, input logic pwr);
        @(posedge clk);
        {prbs_lock, power_normal} <= {lock, pwr};
    endtask : lv
endmodule : pecbc_far_model
`default_nettype wire

// File: tb/testbench.sv
// self-checking testbench for the error counter and self-test register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pecbc_pkg::*;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic [ADDR_W-1:0] avs_address = '0;
    logic              avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0]       avs_writedata = '0, avs_readdata, q;
    logic [3:0]        avs_byteenable = 4'hF;
    logic [LB_W-1:0]   loopback_sel;
    logic avs_waitrequest, false_carrier_evt, rx_dv, rx_symbol_err, mii_loopback, prbs_error_evt, prbs_lock;
    logic prbs_sync_loss_evt, gen_active, power_normal, prbs_count_mode, prbs_packet_mode, gen_enable;
    logic gen_continuous, prbs_checker_en, tx_in_loopback, prbs_count_wrap, fc_half_full_evt, re_half_full_evt;
    int n_errors = 0, checks_done = 0, n_fch = 0, n_reh = 0, n_wrp = 0, cyc = 0;
    always #5 clk = ~clk;
    pecbc_regs DUT (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .false_carrier_evt, .rx_dv, .rx_symbol_err, .mii_loopback,
        .prbs_error_evt, .prbs_lock, .prbs_sync_loss_evt, .gen_active, .power_normal, .prbs_count_mode,
        .prbs_packet_mode, .gen_enable, .gen_continuous, .prbs_checker_en, .tx_in_loopback, .loopback_sel,
        .prbs_count_wrap, .fc_half_full_evt, .re_half_full_evt);
    pecbc_far_model far (.clk, .gen_enable, .false_carrier_evt, .rx_dv, .rx_symbol_err, .mii_loopback,
        .prbs_error_evt, .prbs_lock, .prbs_sync_loss_evt, .gen_active, .power_normal);
    // the ceiling covers the long receive error burst with margin
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (fc_half_full_evt === 1'b1) n_fch <= n_fch + 1;
        if (re_half_full_evt === 1'b1) n_reh <= n_reh + 1;
        if (prbs_count_wrap === 1'b1) n_wrp <= n_wrp + 1;
        if (cyc == 90000) begin
            n_errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} <= {!w, w, a, d, be};
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        q = avs_readdata;
        {avs_read, avs_write} <= 2'b00;
        @(posedge clk);
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        bus(1'b0, a, 32'h0000_0000, 4'hF);
        chk(n, e, q);
    endtask : rd
    task automatic t_reset();
        rd(8'h50, 32'h0000_0000, "fc reset");
        rd(8'h54, 32'h0000_0000, "re reset");
        rd(8'h58, 32'h0000_0000, "st reset");
        rd(8'h00, 32'h0000_0000, "unmapped");
    endtask : t_reset
    task automatic t_fc();
        bus(1'b1, 8'h50, 32'h0000_FFFF, 4'hF);
        far.fc(8'h7F);
        chk("fc below half", 32'h0, n_fch);
        far.fc(1);
        rd(8'h50, 32'h0000_0080, "fc count");
        chk("fc half pulse", 32'h1, n_fch);
        rd(8'h50, 32'h0000_0000, "fc cleared");
        rd(8'h48, 32'h0000_0200, "fc flag");
        far.fc(261);
        rd(8'h50, 32'h0000_00FF, "fc saturate");
        chk("fc half once", 32'h2, n_fch);
    endtask : t_fc
    task automatic t_re();
        far.re(5, 1'b1, 1'b0);
        far.re(3, 1'b0, 1'b0);
        far.re(4, 1'b1, 1'b1);
        rd(8'h54, 32'h0000_0005, "re count");
        // checker on in continuous mode; its errors run alongside the long burst to save cycles
        bus(1'b1, 8'h58, 32'h0000_6000, 4'hF);
        fork
            far.re(32'h1_0002, 1'b1, 1'b0);
            far.pe(32'h1_0000);
        join
        rd(8'h54, 32'h0000_FFFF, "re saturate");
        chk("re half once", 32'h1, n_reh);
        chk("bist wrap", 32'h1, n_wrp);
        bus(1'b1, 8'h48, 32'h0000_0003, 4'hF);
        // false carrier flag was set again by the second crossing in the saturation burst
        rd(8'h48, 32'h0000_0303, "re flag enables");
        rd(8'h54, 32'h0000_0000, "re cleared");
    endtask : t_re
    task automatic t_st();
        far.lv(1'b1, 1'b1);
        bus(1'b1, 8'h58, 32'h0000_F0E4, 4'hF);
        chk("ctl outputs", 32'h7E4, {prbs_count_mode, prbs_packet_mode, gen_enable, gen_continuous,
            prbs_checker_en, tx_in_loopback, loopback_sel});
        rd(8'h58, 32'h0000_7B44, "st status");
        far.sync_loss();
        rd(8'h58, 32'h0000_7F44, "sync latched");
        rd(8'h58, 32'h0000_7B44, "sync cleared");
        bus(1'b1, 8'h58, 32'h0000_7043, 4'hF);
        chk("lb kept", 32'h04, loopback_sel);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, 8'h58, 32'h0000_7040 | (32'h1 << i), 4'hF);
            chk("lb code", 32'h1 << i, loopback_sel);
        end
        bus(1'b1, 8'h58, 32'h0000_0010, 4'h2);
        rd(8'h58, 32'h0000_0950, "st lanes");
        chk("checker off", 32'h0, {gen_continuous, prbs_checker_en, gen_enable});
    endtask : t_st
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_fc();
        t_re();
        t_st();
        end_sim();
    end
endmodule : testbench
`default_nettype wire
